// ---- tmc_pkg.sv ----
package tmc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Bus widths and AHB-Lite encodings
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Control register field positions
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned B_CAPTURE_RELOAD = 0;
   localparam int unsigned B_COUNTER_TIMER = 1;
   localparam int unsigned B_RUN = 2;
   localparam int unsigned B_EXT_ENABLE = 3;
   localparam int unsigned B_TX_BAUD = 4;
   localparam int unsigned B_RX_BAUD = 5;
   localparam int unsigned B_CLK_OUT = 6;
   localparam int unsigned B_SPEED = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Status and mask layout
   localparam int unsigned STAT_W = 2;
   localparam int unsigned S_OVERFLOW = 0;
   localparam int unsigned S_EXT = 1;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Counter and tick constants
   localparam int unsigned CNT_W = 16;
   localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;
   localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam int unsigned BAUD_DIV = 2;
   localparam int unsigned TICK_SLOW_DIV = 12;
   localparam int unsigned TICK_FAST_DIV = 4;
   localparam int unsigned DIV_W = 8;
endpackage : tmc_pkg

// ---- tmc_edge_sync.sv ----
`timescale 1ns/1ps
module tmc_edge_sync
   import tmc_pkg::*;
(
   input wire logic core_clk_in, // Core clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic ce_in, // Clock enable
   input wire logic pin_in, // Asynchronous pin
   output logic fall_out // One-cycle falling edge pulse
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic fall_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reset to high so an idle pin gives no edge after reset
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
         fall_q <= 1'b0;
      end else if (ce_in) begin
         meta_q <= pin_in; // R14
         sync_q <= meta_q;
         prev_q <= sync_q;
         fall_q <= prev_q & ~sync_q; // R14
      end
   end

   assign fall_out = fall_q;

   // A pulse never lasts two enabled cycles
   edge_single_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R14
      ce_in && fall_q |=> !fall_q)
      else $error("edge pulse longer than one cycle");
endmodule : tmc_edge_sync

// ---- tmc_tick_gen.sv ----
`timescale 1ns/1ps
module tmc_tick_gen
   import tmc_pkg::*;
#(
   parameter int unsigned SLOW_DIV = TICK_SLOW_DIV,
   parameter int unsigned FAST_DIV = TICK_FAST_DIV
)(
   input wire logic core_clk_in, // Core clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic ce_in, // Clock enable
   input wire logic half_rate_in, // Baud or clock output mode
   input wire logic speed_in, // Timer speed select
   output logic tick_out // One-cycle tick pulse
);
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] limit;
   logic tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // Divider end value; half rate wins over the speed select
   always_comb begin
      if (half_rate_in) begin
         limit = DIV_W'(BAUD_DIV - 1); // R7
      end else if (speed_in) begin
         limit = DIV_W'(FAST_DIV - 1); // R6
      end else begin
         limit = DIV_W'(SLOW_DIV - 1); // R6
      end
   end

   // Free-running prescaler; >= also recovers when the limit shrinks
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (ce_in) begin
         if (div_q >= limit) begin
            div_q <= '0;
            tick_q <= 1'b1;
         end else begin
            div_q <= div_q + DIV_W'(1);
            tick_q <= 1'b0;
         end
      end
   end

   assign tick_out = tick_q;

   // Half rate gives no two ticks in a row
   half_rate_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R7
      ce_in && half_rate_in && tick_q && div_q == '0 |=> !tick_q)
      else $error("half rate tick came on consecutive cycles");
endmodule : tmc_tick_gen

// ---- tmc_core.sv ----
//
// Overview of operation
// R1 - External enable low ignores trigger pin events
// R2 - Enabled trigger falling edge captures or reloads
// R3 - Trigger function off while generating baud rates
// R4 - Run low halts and holds count
// R5 - Counter mode counts count pin falling edges
// R6 - Timer mode counts ticks, rate by speed
// R7 - Baud or clock out: tick every two clocks
// R8 - Baud source set forces reload on overflow
// R9 - Reload select: reload on overflow or trigger
// R10 - Capture select: capture on enabled trigger edge
// R11 - Capture copies count; reload loads pair
// R12 - Baud source bits force half-rate baud mode
// R13 - Overflow at FFFF to zero sets flag; the code sets no overflow flag in baud mode
// R14 - Pins synchronised, one pulse per edge
// R15 - Reset clears all control bits to zero
//
`timescale 1ns/1ps
module tmc_core
   import tmc_pkg::*;
#(
   parameter int unsigned SLOW_DIV = TICK_SLOW_DIV,
   parameter int unsigned FAST_DIV = TICK_FAST_DIV
)(
   input wire logic core_clk_in, // Core clock, 200 MHz
   input wire logic rstn_in, // Async reset, active low
   input wire logic ce_in, // Clock enable, freezes state when low
   input wire logic hsel_in, // AHB slave select
   input wire logic [ADDR_W-1:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer type
   input wire logic hwrite_in, // AHB write
   input wire logic [2:0] hsize_in, // AHB transfer size
   input wire logic [DATA_W-1:0] hwdata_in, // AHB write data
   input wire logic hready_in, // AHB bus ready
   output logic [DATA_W-1:0] hrdata_out, // AHB read data
   output logic hreadyout_out, // AHB slave ready
   output logic hresp_out, // AHB response
   input wire logic ext_trigger_pin_in, // External trigger pin
   input wire logic count_input_pin_in, // Count input pin
   output logic irq_out, // Interrupt, level, active high
   output logic baud_overflow_out // Overflow pulse to the serial port
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic [CNT_W-1:0] reload_q;
   logic [CNT_W-1:0] reload_d;
   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] status_d;
   logic [STAT_W-1:0] mask_q;
   logic [DATA_W-1:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic irq_q;
   logic baud_ovf_q;
   logic wr_pend_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic addr_ok;
   logic wr_ctrl;
   logic wr_count;
   logic wr_reload;
   logic wr_status;
   logic wr_mask;
   logic ext_fall;
   logic cnt_fall;
   logic gen_tick;
   logic run;
   logic counter_mode;
   logic capture_mode;
   logic ext_enable;
   logic baud_mode;
   logic half_rate;
   logic tick_sel;
   logic ext_act;
   logic ext_capture;
   logic ext_reload;
   logic ovf_evt;
   logic reload_on_ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Address match, shared by the read mux and the write strobes
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offset);
      reg_hit = (addr == offset);
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and tick source
   tmc_edge_sync u_trig_sync (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .pin_in(ext_trigger_pin_in),
      .fall_out(ext_fall)
   );

   tmc_edge_sync u_count_sync (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .pin_in(count_input_pin_in),
      .fall_out(cnt_fall)
   );

   tmc_tick_gen #(
      .SLOW_DIV(SLOW_DIV),
      .FAST_DIV(FAST_DIV)
   ) u_tick (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .half_rate_in(half_rate),
      .speed_in(ctrl_q[B_SPEED]),
      .tick_out(gen_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode from the control bits
   assign run = ctrl_q[B_RUN];
   assign counter_mode = ctrl_q[B_COUNTER_TIMER];
   assign capture_mode = ctrl_q[B_CAPTURE_RELOAD];
   assign ext_enable = ctrl_q[B_EXT_ENABLE];
   assign baud_mode = ctrl_q[B_TX_BAUD] | ctrl_q[B_RX_BAUD]; // R12
   assign half_rate = baud_mode | ctrl_q[B_CLK_OUT]; // R7

   // Tick source: half rate beats the counter/timer select
   always_comb begin
      if (half_rate) begin
         tick_sel = gen_tick; // R7
      end else if (counter_mode) begin
         tick_sel = cnt_fall; // R5
      end else begin
         tick_sel = gen_tick; // R6
      end
   end

   // Trigger events only count when enabled and not in baud mode
   assign ext_act = ext_fall & ext_enable & ~baud_mode; // R1 R2 R3
   assign ext_capture = ext_act & capture_mode; // R10
   // Reload from the pin needs the timer running so a halt holds the count
   assign ext_reload = ext_act & ~capture_mode & run; // R9 R4
   // Baud mode disregards the capture select
   assign reload_on_ovf = baud_mode | ~capture_mode; // R8 R9

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase; only whole-word transfers are taken
   assign addr_ok = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ &&
                    hsize_in == HSIZE_WORD;

   // Write strobes in the data phase
   assign wr_ctrl = wr_pend_q && reg_hit(wr_addr_q, OFF_CTRL);
   assign wr_count = wr_pend_q && reg_hit(wr_addr_q, OFF_COUNT);
   assign wr_reload = wr_pend_q && reg_hit(wr_addr_q, OFF_RELOAD);
   assign wr_status = wr_pend_q && reg_hit(wr_addr_q, OFF_STATUS);
   assign wr_mask = wr_pend_q && reg_hit(wr_addr_q, OFF_MASK);

   // Latch a write address; the data follow one cycle later
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else if (ce_in) begin
         wr_pend_q <= addr_ok && hwrite_in;
         if (addr_ok && hwrite_in) begin
            wr_addr_q <= haddr_in;
         end
      end
   end

   // Read data registered at the address phase, zero for unmapped offsets
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hrdata_q <= '0;
      end else if (ce_in) begin
         if (addr_ok && !hwrite_in) begin
            if (reg_hit(haddr_in, OFF_CTRL)) begin
               hrdata_q <= DATA_W'(ctrl_q);
            end else if (reg_hit(haddr_in, OFF_COUNT)) begin
               hrdata_q <= DATA_W'(count_q);
            end else if (reg_hit(haddr_in, OFF_RELOAD)) begin
               hrdata_q <= DATA_W'(reload_q);
            end else if (reg_hit(haddr_in, OFF_STATUS)) begin
               hrdata_q <= DATA_W'(status_q);
            end else if (reg_hit(haddr_in, OFF_MASK)) begin
               hrdata_q <= DATA_W'(mask_q);
            end else begin
               hrdata_q <= '0;
            end
         end
      end
   end

   // Zero wait states and always OKAY, so these flops never change
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hreadyout_q <= 1'b1;
         hresp_q <= HRESP_OKAY;
      end else if (ce_in) begin
         hreadyout_q <= 1'b1;
         hresp_q <= HRESP_OKAY;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = hwdata_in[CTRL_W-1:0];
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q <= CTRL_RESET; // R15
      end else if (ce_in) begin
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count: software write, then trigger reload, then the tick
   always_comb begin
      count_d = count_q;
      ovf_evt = 1'b0;
      if (wr_count) begin
         count_d = hwdata_in[CNT_W-1:0];
      end else if (ext_reload) begin
         count_d = reload_q; // R9 R11
      end else if (run && tick_sel) begin // R4
         if (count_q == COUNT_MAX) begin
            ovf_evt = 1'b1; // R13
            // Capture mode outside baud mode simply rolls to zero
            count_d = reload_on_ovf ? reload_q : COUNT_RESET; // R8 R11 R13
         end else begin
            count_d = count_q + COUNT_ONE; // R5 R6
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_q <= COUNT_RESET;
      end else if (ce_in) begin
         count_q <= count_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture/reload pair; software write wins over a capture
   always_comb begin
      reload_d = reload_q;
      if (wr_reload) begin
         reload_d = hwdata_in[CNT_W-1:0];
      end else if (ext_capture) begin
         reload_d = count_q; // R10 R11
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reload_q <= COUNT_RESET;
      end else if (ce_in) begin
         reload_q <= reload_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats the clear
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = status_q & ~hwdata_in[STAT_W-1:0];
      end
      if (ovf_evt && !baud_mode) begin
         status_d[S_OVERFLOW] = 1'b1; // R13
      end
      if (ext_act) begin
         status_d[S_EXT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         status_q <= STAT_RESET;
      end else if (ce_in) begin
         status_q <= status_d;
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_q <= STAT_RESET;
      end else if (ce_in && wr_mask) begin
         mask_q <= hwdata_in[STAT_W-1:0];
      end
   end

   // Interrupt and baud pulse, registered so the outputs come from flops
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_q <= 1'b0;
         baud_ovf_q <= 1'b0;
      end else if (ce_in) begin
         irq_q <= |(status_q & mask_q);
         baud_ovf_q <= ovf_evt & baud_mode; // R12
      end
   end

   assign hrdata_out = hrdata_q;
   assign hreadyout_out = hreadyout_q;
   assign hresp_out = hresp_q;
   assign irq_out = irq_q;
   assign baud_overflow_out = baud_ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   halt_hold_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R4
      ce_in && !run && !wr_count |=> count_q == $past(count_q))
      else $error("count moved while halted");

   ext_ignored_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R1
      ce_in && ext_fall && !ext_enable && !wr_reload && !wr_status
      |=> $stable(reload_q) && status_q[S_EXT] == $past(status_q[S_EXT]))
      else $error("trigger acted while disabled");

   baud_ignore_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R3
      ce_in && ext_fall && baud_mode && !wr_reload |=> $stable(reload_q))
      else $error("trigger captured in baud mode");

   capture_copy_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R10
      ce_in && ext_fall && ext_enable && capture_mode && !baud_mode && !wr_reload
      |=> reload_q == $past(count_q) && status_q[S_EXT])
      else $error("capture did not copy the count");

   ext_reload_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R9
      ce_in && ext_fall && ext_enable && !capture_mode && !baud_mode && run && !wr_count
      |=> count_q == $past(reload_q))
      else $error("trigger reload did not load the count");

   ovf_reload_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R8
      ce_in && run && tick_sel && count_q == COUNT_MAX && baud_mode && !wr_count
      |=> count_q == $past(reload_q) && baud_overflow_out)
      else $error("baud overflow did not reload or pulse");

   ovf_flag_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R13
      ce_in && run && tick_sel && count_q == COUNT_MAX && !baud_mode && capture_mode
      && !wr_count && !wr_status |=> status_q[S_OVERFLOW] && count_q == COUNT_RESET)
      else $error("overflow flag or roll to zero missing");

   count_edge_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R5
      ce_in && run && counter_mode && !half_rate && cnt_fall && count_q != COUNT_MAX
      && !wr_count && !ext_reload |=> count_q == $past(count_q) + COUNT_ONE)
      else $error("count pin edge not counted");

   count_quiet_a : assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R5
      ce_in && counter_mode && !half_rate && !cnt_fall && !wr_count && !ext_reload
      |=> $stable(count_q))
      else $error("counter mode moved without an edge");
endmodule : tmc_core

// ---- tmc_pin_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Far side: the trigger and count pins, idle high like a pulled-up port pin
module tmc_pin_model (
   input wire logic core_clk_in, // Core clock, paces the edges only
   output logic ext_trigger_pin_out, // Trigger pin level
   output logic count_input_pin_out // Count pin level
);
   // Both pins rest high between events
   initial begin
      ext_trigger_pin_out = 1'b1;
      count_input_pin_out = 1'b1;
   end

   ////////////////////////////////////////////////////////////
   // One falling edge on the chosen pin; each level lasts hold cycles,
   // never under two, or the synchroniser could miss it
   task automatic fall(input logic trig, input int hold);
      @(posedge core_clk_in);
      if (trig) begin
         ext_trigger_pin_out <= 1'b0;
      end else begin
         count_input_pin_out <= 1'b0;
      end
      repeat (hold) @(posedge core_clk_in);
      ext_trigger_pin_out <= 1'b1;
      count_input_pin_out <= 1'b1;
      repeat (hold) @(posedge core_clk_in);
   endtask : fall
endmodule : tmc_pin_model

// ---- timer2_mode_control_test.sv ----
`timescale 1ns/1ps
module timer2_mode_control_test
   import tmc_pkg::*;
;
   logic core_clk, rstn, hsel, hwrite, hready, hresp, irq, baud_ovf, trig_pin, cnt_pin;
   logic [ADDR_W-1:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [DATA_W-1:0] hwdata, hrdata, rd;
   int failures, comparisons;

   // The one slave's ready is the bus ready; clock enable stays on
   tmc_core u_dut (.core_clk_in(core_clk), .rstn_in(rstn), .ce_in(1'b1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .ext_trigger_pin_in(trig_pin), .count_input_pin_in(cnt_pin),
      .irq_out(irq), .baud_overflow_out(baud_ovf));
   tmc_pin_model u_pins (.core_clk_in(core_clk), .ext_trigger_pin_out(trig_pin),
      .count_input_pin_out(cnt_pin));

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // Single word transfer; an idle cycle always precedes the address phase
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      hsize <= HSIZE_WORD;
      @(posedge core_clk);
      while (hready !== 1'b1)
         @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hready !== 1'b1)
         @(posedge core_clk);
      rd = hrdata;
      chk(32'(hresp), 32'(HRESP_OKAY), "response");
   endtask : bus

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string m);
      bus(1'b0, a, 32'h0);
      chk(rd, exp, m);
   endtask : rdchk

   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////
   // Every register and one unmapped word read zero after reset
   task automatic t_reset;
      for (int a = 0; a <= 20; a += 4) begin
         rdchk(8'(a), 32'h0, "reset value");
      end
      $display("test reset finished");
   endtask : t_reset

   // Run windows of equal length; the count shows the tick rate, then holds once halted
   task automatic t_ticks;
      logic [7:0] cfg [5] = '{8'h04, 8'h84, 8'h14, 8'h24, 8'h46};
      int dv [5] = '{12, 4, 2, 2, 2};
      int got;
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, OFF_CTRL, 32'h0);
         bus(1'b1, OFF_COUNT, 32'h0);
         bus(1'b1, OFF_CTRL, 32'(cfg[i]));
         repeat (96) @(posedge core_clk);
         bus(1'b1, OFF_CTRL, 32'(cfg[i] ^ 8'h04));
         bus(1'b0, OFF_COUNT, 32'h0);
         got = int'(rd[15:0]);
         chk(32'(got >= 99 / dv[i] - 1 && got <= 99 / dv[i] + 1), 32'h1, "tick rate");
         repeat (30) @(posedge core_clk);
         rdchk(OFF_COUNT, 32'(got), "halted count");
      end
      $display("test ticks finished");
   endtask : t_ticks

   // Counter mode: one step per pin fall, quick and slow edges
   task automatic t_count;
      bus(1'b1, OFF_CTRL, 32'h0);
      bus(1'b1, OFF_COUNT, 32'h0);
      bus(1'b1, OFF_CTRL, 32'h06);
      u_pins.fall(1'b0, 2);
      u_pins.fall(1'b0, 5);
      u_pins.fall(1'b0, 2);
      repeat (8) @(posedge core_clk);
      rdchk(OFF_COUNT, 32'h3, "pin count");
      $display("test count finished");
   endtask : t_count

   // Rollover reloads, flags, raises, masks and clears the interrupt
   task automatic t_ovf;
      bus(1'b1, OFF_CTRL, 32'h0);
      bus(1'b1, OFF_RELOAD, 32'hfff0);
      bus(1'b1, OFF_COUNT, 32'hfffe);
      bus(1'b1, OFF_MASK, 32'h1);
      bus(1'b1, OFF_CTRL, 32'h06);
      u_pins.fall(1'b0, 2);
      u_pins.fall(1'b0, 2);
      repeat (8) @(posedge core_clk);
      rdchk(OFF_COUNT, 32'hfff0, "reload on rollover");
      rdchk(OFF_STATUS, 32'h1, "overflow flag");
      chk(32'(irq), 32'h1, "irq raised");
      bus(1'b1, OFF_MASK, 32'h0);
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'h0, "irq masked");
      bus(1'b1, OFF_STATUS, 32'h1);
      rdchk(OFF_STATUS, 32'h0, "flag cleared");
      // Capture mode outside baud mode rolls to zero and still flags
      bus(1'b1, OFF_COUNT, 32'hffff);
      bus(1'b1, OFF_CTRL, 32'h07);
      u_pins.fall(1'b0, 2);
      repeat (8) @(posedge core_clk);
      rdchk(OFF_COUNT, 32'h0, "capture mode rolls to zero");
      rdchk(OFF_STATUS, 32'h1, "flag in capture mode");
      $display("test overflow finished");
   endtask : t_ovf

   // Trigger fall under five control settings; halted baud cases must ignore it
   task automatic t_trig;
      logic [7:0] cfg [5] = '{8'h06, 8'h0e, 8'h0f, 8'h1b, 8'h29};
      logic [15:0] ce [5] = '{16'h0055, 16'h0aaa, 16'h0055, 16'h0055, 16'h0055};
      logic [15:0] re [5] = '{16'h0aaa, 16'h0aaa, 16'h0055, 16'h0aaa, 16'h0aaa};
      logic [1:0] se [5] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0};
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, OFF_CTRL, 32'h0);
         bus(1'b1, OFF_COUNT, 32'h0055);
         bus(1'b1, OFF_RELOAD, 32'h0aaa);
         bus(1'b1, OFF_STATUS, 32'h3);
         bus(1'b1, OFF_CTRL, 32'(cfg[i]));
         u_pins.fall(1'b1, 3);
         repeat (8) @(posedge core_clk);
         rdchk(OFF_COUNT, 32'(ce[i]), "count after trigger");
         rdchk(OFF_RELOAD, 32'(re[i]), "pair after trigger");
         rdchk(OFF_STATUS, 32'(se[i]), "trigger flag");
      end
      $display("test trigger finished");
   endtask : t_trig

   // Baud mode reloads despite capture select and leaves the flag clear
   task automatic t_baud;
      int i;
      bus(1'b1, OFF_CTRL, 32'h0);
      bus(1'b1, OFF_RELOAD, 32'hfff0);
      bus(1'b1, OFF_COUNT, 32'hffe0);
      bus(1'b1, OFF_STATUS, 32'h3);
      bus(1'b1, OFF_CTRL, 32'h15);
      for (i = 0; i < 200 && baud_ovf !== 1'b1; i++)
         @(posedge core_clk);
      chk(32'(baud_ovf), 32'h1, "baud overflow pulse");
      bus(1'b1, OFF_CTRL, 32'h11);
      bus(1'b0, OFF_COUNT, 32'h0);
      chk(32'(rd[15:4] === 12'hfff), 32'h1, "baud reload");
      rdchk(OFF_STATUS, 32'h0, "no flag in baud mode");
      $display("test baud finished");
   endtask : t_baud

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = HSIZE_WORD;
      hwdata = '0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_ticks();
      t_count();
      t_ovf();
      t_trig();
      t_baud();
      end_sim();
   end

   // Watchdog: the tests need just over a thousand cycles, so this margin means a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      end_sim();
   end
endmodule : timer2_mode_control_test
